/* rtl/pdc_pkg.sv */
package pdc_pkg;
    localparam logic [11:0] OFS_MODE     = 12'h101;
    localparam logic [11:0] OFS_BYPASS   = 12'h104;
    localparam logic [11:0] OFS_REFDIV   = 12'h105;
    localparam logic [11:0] OFS_INTVAL   = 12'h107;
    localparam logic [11:0] OFS_FRAC0    = 12'h108;
    localparam logic [11:0] OFS_FRAC1    = 12'h109;
    localparam logic [11:0] OFS_FRAC2    = 12'h10A;
    localparam logic [11:0] OFS_MOD0     = 12'h10B;
    localparam logic [11:0] OFS_MOD1     = 12'h10C;
    localparam logic [11:0] OFS_MOD2     = 12'h10D;
    localparam logic [11:0] OFS_CASC_LO  = 12'h10E;
    localparam logic [11:0] OFS_CASC_HI  = 12'h10F;
    localparam logic [11:0] OFS_FD_RATIO = 12'h110;
    localparam logic [11:0] OFS_FD_PHASE = 12'h111;
    localparam logic [11:0] OFS_PD_CTRL  = 12'h120;
    localparam logic [11:0] OFS_PD_RATIO = 12'h121;
    localparam logic [11:0] OFS_MASK     = 12'h122;
    localparam logic [11:0] OFS_STATUS   = 12'h130;
    localparam int          ADDR_SHIFT   = 2;
    localparam logic [7:0] RST_MODE     = 8'h01;
    localparam logic [7:0] RST_BYPASS   = 8'h00;
    localparam logic [7:0] RST_REFDIV   = 8'h01;
    localparam logic [7:0] RST_INTVAL   = 8'h64;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_PD_CTRL  = 8'h20;
    localparam logic [7:0] RST_PD_RATIO = 8'h44;
    localparam logic [7:0] MASK_MODE    = 8'h07;
    localparam logic [7:0] MASK_BYPASS  = 8'h01;
    localparam logic [7:0] MASK_SIX     = 8'h3F;
    localparam logic [7:0] MASK_NIBBLE  = 8'h0F;
    localparam logic [7:0] MASK_PD_CTRL = 8'h77;
    localparam logic [7:0] MASK_SYNC    = 8'h7F;
    localparam int M0_RST_BIT  = 0;
    localparam int M0_PD_BIT   = 1;
    localparam int M0_SYNC_BIT = 2;
    localparam int M1_RST_BIT  = 4;
    localparam int M1_PD_BIT   = 5;
    localparam int M1_SYNC_BIT = 6;
    localparam logic [3:0] PD_RATIO_MIN = 4'h2;
    localparam logic [3:0] PD_RATIO_MAX = 4'hB;
    localparam logic [11:0] CASC_MIN    = 12'h004;
    localparam logic [7:0] INT_MIN      = 8'h0C;
    localparam logic [7:0] INT_SDM_LO   = 8'h0F;
    localparam logic [7:0] INT_SDM_HI   = 8'hFC;
    typedef enum logic [1:0] {
        PDC_LOOP_SINGLE  = 2'b00,
        PDC_LOOP_CASCADE = 2'b01,
        PDC_LOOP_FIXED   = 2'b10,
        PDC_LOOP_RSVD    = 2'b11
    } pdc_loop_t;
endpackage

/* rtl/pdc_post_div_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module pdc_post_div_ctl (
    input  wire logic [3:0] ratio,
    input  wire logic       pd_bit,
    input  wire logic       rst_bit,
    output logic [3:0]      eff_ratio,
    output logic            running,
    output logic            in_reset
);
    import pdc_pkg::*;
    wire ratio_ok = (ratio >= PD_RATIO_MIN) && (ratio <= PD_RATIO_MAX);
    assign running   = ratio_ok && !pd_bit;
    assign eff_ratio = running ? ratio : 4'h0;
    assign in_reset  = rst_bit;
endmodule // pdc_post_div_ctl
`default_nettype wire

/* rtl/pdc_sync_route.sv */
`timescale 1ns/1ps
`default_nettype none
module pdc_sync_route (
    input  wire logic       m0_sync,
    input  wire logic       m1_sync,
    input  wire logic [6:0] mask,
    output logic [4:0]      hold
);
    // hold bits: 0..3 output dividers zero..three, 4 fixed-delay divider
    assign hold[0] = m0_sync && !mask[0];
    assign hold[1] = (m0_sync && !mask[1]) || (m1_sync && !mask[5]);
    assign hold[2] = (m0_sync && !mask[2]) || (m1_sync && !mask[6]);
    assign hold[3] = m0_sync && !mask[3];
    assign hold[4] = m0_sync && !mask[4];
endmodule // pdc_sync_route
`default_nettype wire

/* rtl/pdc_pll_divider_config.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pdc_pll_divider_config (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             loop_filter_bypass,
    output logic [5:0]       reference_predivider,
    output logic             ref_div_valid,
    output logic [7:0]       feedback_integer_divider,
    output logic             int_value_legal,
    output logic [23:0]      sdm_fraction,
    output logic [23:0]      sdm_modulus,
    output logic             sdm_powerdown,
    output logic [11:0]      cascaded_feedback_divider,
    output logic             cascade_valid,
    output logic [6:0]       fixed_delay_divider,
    output logic [5:0]       fixed_delay_phase,
    output logic [1:0]       loop_mode,
    output logic             sel_single,
    output logic             sel_cascade,
    output logic             sel_fixed,
    output logic [3:0]       first_post_divider,
    output logic             first_post_running,
    output logic             first_post_reset,
    output logic [3:0]       second_post_divider,
    output logic             second_post_running,
    output logic             second_post_reset,
    output logic [4:0]       divider_sync_hold
);
    import pdc_pkg::*;

    logic [7:0] mode_reg;
    logic [7:0] bypass_reg;
    logic [7:0] refdiv_reg;
    logic [7:0] intval_reg;
    logic [7:0] frac0, frac1, frac2;
    logic [7:0] mod0, mod1, mod2;
    logic [7:0] casc_lo, casc_hi;
    logic [7:0] fd_ratio, fd_phase;
    logic [7:0] pd_ctrl, pd_ratio, sync_mask;

    function automatic logic [13:0] byte_addr(input logic [11:0] ofs);
        byte_addr = {ofs, 2'b00};
    endfunction

    // address decode
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire [7:0] wb = pwdata[7:0];
    wire hit_mode   = paddr == byte_addr(OFS_MODE);
    wire hit_byp    = paddr == byte_addr(OFS_BYPASS);
    wire hit_ref    = paddr == byte_addr(OFS_REFDIV);
    wire hit_int    = paddr == byte_addr(OFS_INTVAL);
    wire hit_f0     = paddr == byte_addr(OFS_FRAC0);
    wire hit_f1     = paddr == byte_addr(OFS_FRAC1);
    wire hit_f2     = paddr == byte_addr(OFS_FRAC2);
    wire hit_m0     = paddr == byte_addr(OFS_MOD0);
    wire hit_m1     = paddr == byte_addr(OFS_MOD1);
    wire hit_m2     = paddr == byte_addr(OFS_MOD2);
    wire hit_clo    = paddr == byte_addr(OFS_CASC_LO);
    wire hit_chi    = paddr == byte_addr(OFS_CASC_HI);
    wire hit_fdr    = paddr == byte_addr(OFS_FD_RATIO);
    wire hit_fdp    = paddr == byte_addr(OFS_FD_PHASE);
    wire hit_pdc    = paddr == byte_addr(OFS_PD_CTRL);
    wire hit_pdr    = paddr == byte_addr(OFS_PD_RATIO);
    wire hit_msk    = paddr == byte_addr(OFS_MASK);
    wire hit_sts    = paddr == byte_addr(OFS_STATUS);
    wire hit_any    = hit_mode | hit_byp | hit_ref | hit_int | hit_f0 | hit_f1 | hit_f2
                    | hit_m0 | hit_m1 | hit_m2 | hit_clo | hit_chi | hit_fdr | hit_fdp
                    | hit_pdc | hit_pdr | hit_msk | hit_sts;

    // derived state
    wire [11:0] casc_ratio = {casc_hi[3:0], casc_lo};
    wire [7:0]  status_byte;
    wire [3:0]  m0_eff, m1_eff;
    wire        m0_run, m1_run, m0_rst, m1_rst;
    wire [4:0]  hold;
    wire        sdm_off = mode_reg[0];
    wire        int_ok  = (intval_reg >= INT_SDM_LO && intval_reg <= INT_SDM_HI)
                        || (intval_reg >= INT_MIN && sdm_off);
    assign status_byte = {3'b000, m1_run, m0_run, (casc_ratio >= CASC_MIN), int_ok,
                          (refdiv_reg[5:0] != 6'h00)};

    pdc_post_div_ctl u_m0 (
        .ratio     (pd_ratio[3:0]),
        .pd_bit    (pd_ctrl[M0_PD_BIT]),
        .rst_bit   (pd_ctrl[M0_RST_BIT]),
        .eff_ratio (m0_eff),
        .running   (m0_run),
        .in_reset  (m0_rst)
    );
    pdc_post_div_ctl u_m1 (
        .ratio     (pd_ratio[7:4]),
        .pd_bit    (pd_ctrl[M1_PD_BIT]),
        .rst_bit   (pd_ctrl[M1_RST_BIT]),
        .eff_ratio (m1_eff),
        .running   (m1_run),
        .in_reset  (m1_rst)
    );
    pdc_sync_route u_sync (
        .m0_sync (pd_ctrl[M0_SYNC_BIT]),
        .m1_sync (pd_ctrl[M1_SYNC_BIT]),
        .mask    (sync_mask[6:0]),
        .hold    (hold)
    );

    // read mux, reserved bits already zero in storage
    wire [7:0] rd_byte =
          hit_mode ? mode_reg  : hit_byp ? bypass_reg : hit_ref ? refdiv_reg
        : hit_int  ? intval_reg: hit_f0  ? frac0      : hit_f1  ? frac1
        : hit_f2   ? frac2     : hit_m0  ? mod0       : hit_m1  ? mod1
        : hit_m2   ? mod2      : hit_clo ? casc_lo    : hit_chi ? casc_hi
        : hit_fdr  ? fd_ratio  : hit_fdp ? fd_phase   : hit_pdc ? pd_ctrl
        : hit_pdr  ? pd_ratio  : hit_msk ? sync_mask  : hit_sts ? status_byte
        : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg   <= RST_MODE;
            bypass_reg <= RST_BYPASS;
            refdiv_reg <= RST_REFDIV;
            intval_reg <= RST_INTVAL;
            frac0      <= RST_ZERO;
            frac1      <= RST_ZERO;
            frac2      <= RST_ZERO;
            mod0       <= RST_ZERO;
            mod1       <= RST_ZERO;
            mod2       <= RST_ZERO;
            casc_lo    <= RST_ZERO;
            casc_hi    <= RST_ZERO;
            fd_ratio   <= RST_ZERO;
            fd_phase   <= RST_ZERO;
            pd_ctrl    <= RST_PD_CTRL;
            pd_ratio   <= RST_PD_RATIO;
            sync_mask  <= RST_ZERO;
        end else if (wr) begin
            if (hit_mode) mode_reg   <= wb & MASK_MODE;
            if (hit_byp)  bypass_reg <= wb & MASK_BYPASS;
            if (hit_ref)  refdiv_reg <= wb & MASK_SIX;
            if (hit_int)  intval_reg <= wb;
            if (hit_f0)   frac0      <= wb;
            if (hit_f1)   frac1      <= wb;
            if (hit_f2)   frac2      <= wb;
            if (hit_m0)   mod0       <= wb;
            if (hit_m1)   mod1       <= wb;
            if (hit_m2)   mod2       <= wb;
            if (hit_clo)  casc_lo    <= wb;
            if (hit_chi)  casc_hi    <= wb & MASK_NIBBLE;
            if (hit_fdr)  fd_ratio   <= wb & MASK_SIX;
            if (hit_fdp)  fd_phase   <= wb & MASK_SIX;
            if (hit_pdc)  pd_ctrl    <= wb & MASK_PD_CTRL;
            if (hit_pdr)  pd_ratio   <= wb;
            if (hit_msk)  sync_mask  <= wb & MASK_SYNC;
        end
    end

    // bus answer: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : prdata;
        end
    end

    // registered config outputs, one cycle behind the register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_filter_bypass        <= 1'b0;
            reference_predivider      <= 6'h01;
            ref_div_valid             <= 1'b1;
            feedback_integer_divider  <= RST_INTVAL;
            int_value_legal           <= 1'b1;
            sdm_fraction              <= 24'h00_0000;
            sdm_modulus               <= 24'h00_0000;
            sdm_powerdown             <= 1'b1;
            cascaded_feedback_divider <= 12'h000;
            cascade_valid             <= 1'b0;
            fixed_delay_divider       <= 7'h01;
            fixed_delay_phase         <= 6'h00;
            loop_mode                 <= 2'b00;
            sel_single                <= 1'b1;
            sel_cascade               <= 1'b0;
            sel_fixed                 <= 1'b0;
            first_post_divider        <= 4'h4;
            first_post_running        <= 1'b1;
            first_post_reset          <= 1'b0;
            second_post_divider       <= 4'h0;
            second_post_running       <= 1'b0;
            second_post_reset         <= 1'b0;
            divider_sync_hold         <= 5'h00;
        end else begin
            loop_filter_bypass        <= bypass_reg[0];
            reference_predivider      <= refdiv_reg[5:0];
            ref_div_valid             <= refdiv_reg[5:0] != 6'h00;
            feedback_integer_divider  <= intval_reg;
            int_value_legal           <= int_ok;
            sdm_fraction              <= {frac2, frac1, frac0};
            sdm_modulus               <= {mod2, mod1, mod0};
            sdm_powerdown             <= sdm_off;
            cascaded_feedback_divider <= casc_ratio;
            cascade_valid             <= casc_ratio >= CASC_MIN;
            fixed_delay_divider       <= {1'b0, fd_ratio[5:0]} + 7'h01;
            fixed_delay_phase         <= fd_phase[5:0];
            loop_mode                 <= mode_reg[2:1];
            sel_single                <= mode_reg[2:1] == PDC_LOOP_SINGLE;
            sel_cascade               <= mode_reg[2:1] == PDC_LOOP_CASCADE;
            sel_fixed                 <= mode_reg[2:1] == PDC_LOOP_FIXED;
            first_post_divider        <= m0_eff;
            first_post_running        <= m0_run;
            first_post_reset          <= m0_rst;
            second_post_divider       <= m1_eff;
            second_post_running       <= m1_run;
            second_post_reset         <= m1_rst;
            divider_sync_hold         <= hold;
        end
    end
endmodule // pdc_pll_divider_config
`default_nettype wire

/* verif/pdc_pll_divider_config_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pdc_pll_divider_config_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  reference_predivider,
    input wire logic        ref_div_valid,
    input wire logic [7:0]  feedback_integer_divider,
    input wire logic        int_value_legal,
    input wire logic        sdm_powerdown,
    input wire logic [11:0] cascaded_feedback_divider,
    input wire logic        cascade_valid,
    input wire logic [6:0]  fixed_delay_divider,
    input wire logic [1:0]  loop_mode,
    input wire logic        sel_single,
    input wire logic        sel_cascade,
    input wire logic [3:0]  first_post_divider,
    input wire logic        first_post_running
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_refdiv_valid: assert property (ref_div_valid == (reference_predivider != 6'h00))
        else $error("predivider valid flag wrong");
    a_int_legal: assert property (int_value_legal == (
        (feedback_integer_divider inside {[15:252]})
        || (sdm_powerdown && feedback_integer_divider >= 8'h0C)))
        else $error("integer legal flag wrong");
    a_cascade_valid: assert property (cascade_valid == (cascaded_feedback_divider >= 12'h004))
        else $error("cascade valid flag wrong");
    a_fixed_range: assert property (fixed_delay_divider inside {[1:64]})
        else $error("fixed delay ratio out of range");
    a_loop_select: assert property (sel_single == (loop_mode == 2'b00)
        && sel_cascade == (loop_mode == 2'b01))
        else $error("loop select wrong");
    a_post_span: assert property (first_post_running == (first_post_divider inside {[2:11]}))
        else $error("post divider run state wrong");
endmodule // pdc_pll_divider_config_asserts

bind pdc_pll_divider_config pdc_pll_divider_config_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .reference_predivider(reference_predivider),
    .ref_div_valid(ref_div_valid), .feedback_integer_divider(feedback_integer_divider),
    .int_value_legal(int_value_legal), .sdm_powerdown(sdm_powerdown),
    .cascaded_feedback_divider(cascaded_feedback_divider), .cascade_valid(cascade_valid),
    .fixed_delay_divider(fixed_delay_divider), .loop_mode(loop_mode),
    .sel_single(sel_single), .sel_cascade(sel_cascade),
    .first_post_divider(first_post_divider), .first_post_running(first_post_running));
`default_nettype wire

/* verif/pdc_pll_divider_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pdc_pll_divider_config_tb;
    import pdc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        loop_filter_bypass, ref_div_valid, int_value_legal, sdm_powerdown;
    logic        cascade_valid, sel_single, sel_cascade, sel_fixed;
    logic        first_post_running, first_post_reset, second_post_running, second_post_reset;
    logic [5:0]  reference_predivider, fixed_delay_phase;
    logic [7:0]  feedback_integer_divider;
    logic [23:0] sdm_fraction, sdm_modulus;
    logic [11:0] cascaded_feedback_divider;
    logic [6:0]  fixed_delay_divider;
    logic [1:0]  loop_mode;
    logic [3:0]  first_post_divider, second_post_divider;
    logic [4:0]  divider_sync_hold;
    int          n_fail, checks_done;
    logic [11:0] ofs_t [17] = '{OFS_MODE, OFS_BYPASS, OFS_REFDIV, OFS_INTVAL, OFS_FRAC0,
        OFS_FRAC1, OFS_FRAC2, OFS_MOD0, OFS_MOD1, OFS_MOD2, OFS_CASC_LO, OFS_CASC_HI,
        OFS_FD_RATIO, OFS_FD_PHASE, OFS_PD_CTRL, OFS_PD_RATIO, OFS_MASK};
    logic [7:0]  rst_t [17] = '{8'h01, 8'h00, 8'h01, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h44, 8'h00};
    logic [7:0]  msk_t [17] = '{8'h07, 8'h01, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h3F, 8'h77, 8'hFF, 8'h7F};
    logic [7:0]  sy_t [5][3] = '{'{8'h04, 8'h00, 8'h1F}, '{8'h04, 8'h15, 8'h0A},
        '{8'h40, 8'h00, 8'h06}, '{8'h40, 8'h20, 8'h04}, '{8'h44, 8'h7F, 8'h00}};

    pdc_pll_divider_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_filter_bypass(loop_filter_bypass),
        .reference_predivider(reference_predivider), .ref_div_valid(ref_div_valid),
        .feedback_integer_divider(feedback_integer_divider), .int_value_legal(int_value_legal),
        .sdm_fraction(sdm_fraction), .sdm_modulus(sdm_modulus), .sdm_powerdown(sdm_powerdown),
        .cascaded_feedback_divider(cascaded_feedback_divider), .cascade_valid(cascade_valid),
        .fixed_delay_divider(fixed_delay_divider), .fixed_delay_phase(fixed_delay_phase),
        .loop_mode(loop_mode), .sel_single(sel_single), .sel_cascade(sel_cascade),
        .sel_fixed(sel_fixed), .first_post_divider(first_post_divider),
        .first_post_running(first_post_running), .first_post_reset(first_post_reset),
        .second_post_divider(second_post_divider), .second_post_running(second_post_running),
        .second_post_reset(second_post_reset), .divider_sync_hold(divider_sync_hold));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic xfer(input logic [11:0] ofs, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {ofs, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(pready, 1, "no ready");
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr_settle(input logic [11:0] ofs, input logic [7:0] d);
        xfer(ofs, 1'b1, {24'h000000, d});
        repeat (2) @(posedge pclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        #200000;
        n_fail++;
        results();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({loop_filter_bypass, reference_predivider, feedback_integer_divider}, 15'h0164, "rst cfg");
        chk({sdm_powerdown, fixed_delay_divider, divider_sync_hold}, 13'h1020, "rst misc");
        chk({first_post_running, first_post_divider, second_post_running, second_post_divider},
            10'h280, "rst post");
        for (int i = 0; i < 17; i++) begin
            xfer(ofs_t[i], 1'b0, 32'h0);
            chk(q, {24'h0, rst_t[i]}, "reset value");
        end
        xfer(OFS_STATUS, 1'b0, 32'h0);
        chk(q, 32'h0000000B, "reset status");
        $display("test reset values done");
        for (int i = 0; i < 17; i++) xfer(ofs_t[i], 1'b1, 32'hFFFFFFFF);
        for (int i = 0; i < 17; i++) begin
            xfer(ofs_t[i], 1'b0, 32'h0);
            chk(q, {24'h0, msk_t[i]}, "all ones readback");
        end
        repeat (2) @(posedge pclk);
        chk({loop_filter_bypass, reference_predivider, feedback_integer_divider}, 15'h7FFF, "ones cfg");
        chk({fixed_delay_divider, fixed_delay_phase}, 13'h103F, "ones fixed");
        chk({cascaded_feedback_divider, first_post_divider, first_post_reset}, 17'h1FFE1, "ones post");
        chk(divider_sync_hold, 0, "ones masked sync");
        $display("test all ones done");
        xfer(12'h106, 1'b1, 32'hFF);
        chk(e, 1, "unmapped write err");
        xfer(12'h106, 1'b0, 32'h0);
        chk({e, q[30:0]}, 32'h80000000, "unmapped read");
        $display("test unmapped done");
        wr_settle(OFS_FRAC0, 8'h12); wr_settle(OFS_FRAC1, 8'h34); wr_settle(OFS_FRAC2, 8'h56);
        wr_settle(OFS_MOD0, 8'h78); wr_settle(OFS_MOD1, 8'h9A); wr_settle(OFS_MOD2, 8'hBC);
        wr_settle(OFS_CASC_HI, 8'h00); wr_settle(OFS_CASC_LO, 8'h03);
        wr_settle(OFS_FD_RATIO, 8'h00); wr_settle(OFS_FD_PHASE, 8'h15);
        chk({sdm_fraction, sdm_modulus[23:16]}, 32'h563412BC, "fraction order");
        chk({sdm_modulus[15:0], cascaded_feedback_divider}, 28'h9A78003, "modulus cascade");
        chk({fixed_delay_divider, fixed_delay_phase}, 13'h0055, "fixed delay");
        wr_settle(OFS_CASC_LO, 8'h04);
        chk(cascaded_feedback_divider, 12'h004, "cascade four");
        for (int m = 0; m < 4; m++) begin
            wr_settle(OFS_MODE, 8'(m << 1));
            chk({loop_mode, sel_fixed, sel_cascade, sel_single},
                {m[1:0], (m == 3) ? 3'b000 : 3'(1 << m)}, "loop mode");
        end
        $display("test feedback fields done");
        wr_settle(OFS_PD_CTRL, 8'h00); wr_settle(OFS_PD_RATIO, 8'h2B);
        chk({first_post_running, first_post_divider, second_post_running, second_post_divider},
            10'h372, "ratios in range");
        wr_settle(OFS_PD_RATIO, 8'hC1);
        chk({first_post_running, first_post_divider, second_post_running, second_post_divider},
            10'h000, "ratios out of range");
        wr_settle(OFS_PD_RATIO, 8'h44); wr_settle(OFS_PD_CTRL, 8'h22);
        chk({first_post_running, second_post_running}, 2'b00, "power down bits");
        wr_settle(OFS_PD_CTRL, 8'h11);
        chk({first_post_reset, second_post_reset, first_post_running}, 3'b111, "reset bits");
        for (int i = 0; i < 5; i++) begin
            wr_settle(OFS_MASK, sy_t[i][1]);
            wr_settle(OFS_PD_CTRL, sy_t[i][0]);
            chk(divider_sync_hold, sy_t[i][2][4:0], "sync hold");
        end
        wr_settle(OFS_PD_CTRL, 8'h00);
        chk(divider_sync_hold, 0, "sync released");
        $display("test post dividers done");
        results();
    end
endmodule // pdc_pll_divider_config_tb
`default_nettype wire
